/* File: design/event_status.sv */
`timescale 1ns/1ps
module event_status (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                nrst,
  // Events and clears
  input  wire logic [irq_enable_pkg::STATUS_W-1:0] setEvents,
  input  wire logic [irq_enable_pkg::STATUS_W-1:0] clearBits,
  // Mask write
  input  wire logic                                maskWe,
  input  wire logic [irq_enable_pkg::STATUS_W-1:0] maskData,
  // State
  output logic      [irq_enable_pkg::STATUS_W-1:0] status,
  output logic      [irq_enable_pkg::STATUS_W-1:0] mask,
  output logic                                     irq
);
  logic [irq_enable_pkg::STATUS_W-1:0] mask_ff;

  genvar i;
  generate
    for (i = 0; i < irq_enable_pkg::STATUS_W; i = i + 1) begin : g_bit
      logic bit_ff;
      // A new event at the clearing edge survives
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          bit_ff <= 1'b0;
        end else begin
          bit_ff <= setEvents[i] | (bit_ff & ~clearBits[i]);
        end
      end
      assign status[i] = bit_ff;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff <= irq_enable_pkg::MASK_RST;
    end else if (maskWe) begin
      mask_ff <= maskData;
    end
  end

  assign mask = mask_ff;
  assign irq  = |(status & mask_ff);
endmodule

/* File: design/irq_enable_pkg.sv */
package irq_enable_pkg;

  // Byte offsets on the Avalon-MM slave
  localparam logic [4:0] CONTROL_OFS = 5'h00;
  localparam logic [4:0] ENABLE0_OFS = 5'h04;
  localparam logic [4:0] ENABLE1_OFS = 5'h08;
  localparam logic [4:0] FLAG0_OFS   = 5'h0c;
  localparam logic [4:0] STATUS_OFS  = 5'h10;
  localparam logic [4:0] MASK_OFS    = 5'h14;

  // interrupt_control_reg fields
  localparam int GLOBAL_BIT        = 7;
  localparam int PERIPH_MASTER_BIT = 6;
  localparam int EDGE_SEL_BIT      = 0;
  localparam logic [7:0] CONTROL_IMPL = 8'hc1;
  localparam logic [7:0] CONTROL_RST  = 8'h00;

  // interrupt_enable_0 fields
  localparam int TIMER0_EN_BIT     = 5;
  localparam int PIN_CHANGE_EN_BIT = 4;
  localparam int EXT_EN_BIT        = 0;
  localparam logic [7:0] ENABLE0_IMPL = 8'h31;
  localparam logic [7:0] ENABLE0_RST  = 8'h00;

  // interrupt_enable_1 fields
  localparam int TIMER1_GATE_EN_BIT = 7;
  localparam int CONV_DONE_EN_BIT   = 6;
  localparam int RECEIVE_EN_BIT     = 5;
  localparam int TRANSMIT_EN_BIT    = 4;
  localparam int SYNC_PORT_EN_BIT   = 3;
  localparam int COLLISION_EN_BIT   = 2;
  localparam int TIMER2_EN_BIT      = 1;
  localparam int TIMER1_EN_BIT      = 0;
  localparam logic [7:0] ENABLE1_IMPL = 8'hff;
  localparam logic [7:0] ENABLE1_RST  = 8'h00;

  // Flag view register: bit 0 is the external pin flag, bits 4 and 5 mirror inputs, others read zero
  localparam int EXT_FLAG_BIT    = 0;
  localparam int PIN_CHANGE_FLAG = 4;
  localparam int TIMER0_FLAG     = 5;

  // Sticky event status, mask of the same layout
  localparam int STATUS_W       = 3;
  localparam int EV_EXT_EDGE    = 0;
  localparam int EV_CPU_REQ     = 1;
  localparam int EV_PERIPH_REQ  = 2;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } busState_type;

endpackage

/* File: design/peripheral_interrupt_enables.sv */
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module peripheral_interrupt_enables (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Interrupt sources
  input  wire logic        extPin,
  input  wire logic        timer0OverflowFlag,
  input  wire logic        pinChangeFlag,
  input  wire logic [7:0]  periphFlags,
  // Requests to the core
  output logic             cpuInterruptRequest,
  output logic             peripheralRequest,
  output logic             externalRequest,
  output logic             irq
);
  irq_enable_pkg::busState_type busState_ff;
  irq_enable_pkg::busState_type nxt_busState;

  logic [7:0]  control_ff;
  logic [7:0]  enable0_ff;
  logic [7:0]  enable1_ff;
  logic        extFlag_ff;
  logic [31:0] readdata_ff;
  logic        cpuReq_ff;
  logic        periphReq_ff;
  logic        extReq_ff;
  logic        edgePulse;
  logic        pinLevel;
  logic [irq_enable_pkg::STATUS_W-1:0] status;
  logic [irq_enable_pkg::STATUS_W-1:0] mask;

  // Bus decode
  wire request   = read | write;
  wire inAnswer  = (busState_ff == irq_enable_pkg::BUS_ANSWER);
  wire wrAccept  = inAnswer && write && byteenable[0];
  wire rdAccept  = inAnswer && read;
  wire hitCtl    = (address == irq_enable_pkg::CONTROL_OFS);
  wire hitEn0    = (address == irq_enable_pkg::ENABLE0_OFS);
  wire hitEn1    = (address == irq_enable_pkg::ENABLE1_OFS);
  wire hitFlag0  = (address == irq_enable_pkg::FLAG0_OFS);
  wire hitStatus = (address == irq_enable_pkg::STATUS_OFS);
  wire hitMask   = (address == irq_enable_pkg::MASK_OFS);
  wire wrCtl     = wrAccept && hitCtl;
  wire wrEn0     = wrAccept && hitEn0;
  wire wrEn1     = wrAccept && hitEn1;
  wire wrFlag0   = wrAccept && hitFlag0;
  wire wrMask    = wrAccept && hitMask;
  wire [7:0] wByte = writedata[7:0];

  // Field views
  wire globalEn    = control_ff[irq_enable_pkg::GLOBAL_BIT];
  wire periphMstEn = control_ff[irq_enable_pkg::PERIPH_MASTER_BIT];
  wire edgeSel     = control_ff[irq_enable_pkg::EDGE_SEL_BIT];
  wire timer0En    = enable0_ff[irq_enable_pkg::TIMER0_EN_BIT];
  wire pinChangeEn = enable0_ff[irq_enable_pkg::PIN_CHANGE_EN_BIT];
  wire extEn       = enable0_ff[irq_enable_pkg::EXT_EN_BIT];

  // Request terms
  wire [7:0] periphHits  = periphFlags & enable1_ff;
  wire extTerm     = extFlag_ff && extEn;
  wire pinChgTerm  = pinChangeFlag && pinChangeEn;
  wire timer0Term  = timer0OverflowFlag && timer0En;
  wire periphTerm  = globalEn && periphMstEn && (|periphHits);
  wire extNext     = globalEn && extTerm;
  wire cpuNext     = (globalEn && (extTerm || pinChgTerm || timer0Term)) || periphTerm;

  // Read selection; unimplemented bits come back as zero
  wire [7:0] flag0View = {2'b00, timer0OverflowFlag, pinChangeFlag, 3'b000, extFlag_ff};
  wire [7:0] statusView = {{(8 - irq_enable_pkg::STATUS_W){1'b0}}, status};
  wire [7:0] maskView   = {{(8 - irq_enable_pkg::STATUS_W){1'b0}}, mask};
  wire [7:0] readByte =
    hitCtl    ? (control_ff & irq_enable_pkg::CONTROL_IMPL) :
    hitEn0    ? (enable0_ff & irq_enable_pkg::ENABLE0_IMPL) :
    hitEn1    ? enable1_ff :
    hitFlag0  ? flag0View :
    hitStatus ? statusView :
    hitMask   ? maskView : 8'h00;

  // Only bits actually returned to software are cleared, so later events stay
  wire [irq_enable_pkg::STATUS_W-1:0] statusClear =
    (rdAccept && hitStatus) ? readdata_ff[irq_enable_pkg::STATUS_W-1:0]
                            : {irq_enable_pkg::STATUS_W{1'b0}};
  wire [irq_enable_pkg::STATUS_W-1:0] events = {
    periphTerm && !periphReq_ff,
    cpuNext && !cpuReq_ff,
    edgePulse
  };
  wire extClear = wrFlag0 && wByte[irq_enable_pkg::EXT_FLAG_BIT];

  always_comb begin
    nxt_busState = busState_ff;
    unique case (busState_ff)
      irq_enable_pkg::BUS_IDLE: begin
        if (request) begin
          nxt_busState = irq_enable_pkg::BUS_ANSWER;
        end
      end
      irq_enable_pkg::BUS_ANSWER: begin
        nxt_busState = irq_enable_pkg::BUS_IDLE;
      end
      default: begin
        nxt_busState = irq_enable_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busState_ff <= irq_enable_pkg::BUS_IDLE;
      readdata_ff <= 32'h00000000;
    end else begin
      busState_ff <= nxt_busState;
      if (!inAnswer && request) begin
        readdata_ff <= {24'h000000, readByte};
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      control_ff <= irq_enable_pkg::CONTROL_RST;
      enable0_ff <= irq_enable_pkg::ENABLE0_RST;
      enable1_ff <= irq_enable_pkg::ENABLE1_RST;
    end else begin
      if (wrCtl) begin
        control_ff <= wByte & irq_enable_pkg::CONTROL_IMPL;
      end
      if (wrEn0) begin
        enable0_ff <= wByte & irq_enable_pkg::ENABLE0_IMPL;
      end
      if (wrEn1) begin
        enable1_ff <= wByte & irq_enable_pkg::ENABLE1_IMPL;
      end
    end
  end

  // External flag: write one to clear, a fresh edge wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      extFlag_ff <= 1'b0;
    end else begin
      extFlag_ff <= edgePulse | (extFlag_ff & ~extClear);
    end
  end

  // Registered requests cost one cycle but keep the core's inputs glitch free
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpuReq_ff    <= 1'b0;
      periphReq_ff <= 1'b0;
      extReq_ff    <= 1'b0;
    end else begin
      cpuReq_ff    <= cpuNext;
      periphReq_ff <= periphTerm;
      extReq_ff    <= extNext;
    end
  end

  pin_edge_sync u_pin_sync (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .pinAsync  (extPin),
    .risingSel (edgeSel),
    .edgePulse (edgePulse),
    .pinLevel  (pinLevel)
  );

  event_status u_status (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .setEvents (events),
    .clearBits (statusClear),
    .maskWe    (wrMask),
    .maskData  (wByte[irq_enable_pkg::STATUS_W-1:0]),
    .status    (status),
    .mask      (mask),
    .irq       (irq)
  );

  assign waitrequest         = !inAnswer;
  assign readdata            = readdata_ff;
  assign cpuInterruptRequest = cpuReq_ff;
  assign peripheralRequest   = periphReq_ff;
  assign externalRequest     = extReq_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_pin_change_store;
    wrEn0 |=> (pinChangeEn == $past(writedata[4]));
  endproperty
  a_pin_change_store: assert property (p_pin_change_store)
    else $error("pin change enable not stored");

  property p_pin_change_req;
    (globalEn && pinChangeFlag && pinChangeEn) |=> cpuInterruptRequest;
  endproperty
  a_pin_change_req: assert property (p_pin_change_req)
    else $error("pin change request missing");

  property p_transmit_store;
    wrEn1 |=> (enable1_ff[irq_enable_pkg::TRANSMIT_EN_BIT] == $past(writedata[4]));
  endproperty
  a_transmit_store: assert property (p_transmit_store)
    else $error("transmit enable not stored");

  property p_sync_store;
    wrEn1 |=> (enable1_ff[irq_enable_pkg::SYNC_PORT_EN_BIT] == $past(writedata[3]));
  endproperty
  a_sync_store: assert property (p_sync_store)
    else $error("sync port enable not stored");

  property p_collision_store;
    wrEn1 |=> (enable1_ff[irq_enable_pkg::COLLISION_EN_BIT] == $past(writedata[2]));
  endproperty
  a_collision_store: assert property (p_collision_store)
    else $error("collision enable not stored");

  property p_transmit_gate;
    (periphFlags == 8'h10 && globalEn && periphMstEn)
      |=> (peripheralRequest == $past(enable1_ff[irq_enable_pkg::TRANSMIT_EN_BIT]));
  endproperty
  a_transmit_gate: assert property (p_transmit_gate)
    else $error("transmit enable does not decide its request");

  property p_edge_polarity;
    edgePulse |=> (extFlag_ff && pinLevel == $past(edgeSel));
  endproperty
  a_edge_polarity: assert property (p_edge_polarity)
    else $error("external flag set on wrong edge");

  property p_ext_vector;
    (extFlag_ff && extEn && globalEn) |=> (externalRequest && cpuInterruptRequest);
  endproperty
  a_ext_vector: assert property (p_ext_vector)
    else $error("external request not raised");

  property p_periph_all;
    peripheralRequest |-> $past(globalEn && periphMstEn && (|(periphFlags & enable1_ff)));
  endproperty
  a_periph_all: assert property (p_periph_all)
    else $error("peripheral request without all enables");

  property p_unused_zero;
    (rdAccept && hitCtl) |-> (readdata[5:1] == 5'h00 && readdata[31:8] == 24'h000000);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unimplemented bits read nonzero");

  property p_pin_change_block;
    (!pinChangeEn && !extTerm && !timer0Term && !periphTerm) |=> !cpuInterruptRequest;
  endproperty
  a_pin_change_block: assert property (p_pin_change_block)
    else $error("request raised with pin change disabled");

  property p_sync_gate;
    (periphFlags == 8'h08 && globalEn && periphMstEn)
      |=> (peripheralRequest == $past(enable1_ff[irq_enable_pkg::SYNC_PORT_EN_BIT]));
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("sync port enable does not decide its request");

  property p_collision_gate;
    (periphFlags == 8'h04 && globalEn && periphMstEn)
      |=> (peripheralRequest == $past(enable1_ff[irq_enable_pkg::COLLISION_EN_BIT]));
  endproperty
  a_collision_gate: assert property (p_collision_gate)
    else $error("collision enable does not decide its request");

  property p_ext_blocked;
    !globalEn |=> !externalRequest;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked)
    else $error("external request without global enable");

  property p_ext_flag_clear;
    (extClear && !edgePulse) |=> !extFlag_ff;
  endproperty
  a_ext_flag_clear: assert property (p_ext_flag_clear)
    else $error("external flag not cleared by write");

  property p_periph_needs_master;
    !periphMstEn |=> !peripheralRequest;
  endproperty
  a_periph_needs_master: assert property (p_periph_needs_master)
    else $error("peripheral request without peripheral master enable");

  c_ext_request: cover property (edgePulse ##[1:4] externalRequest);
  c_status_read: cover property (rdAccept && hitStatus && readdata[0]);
  c_transmit_req: cover property (periphFlags[4] && enable1_ff[4] && periphMstEn
                                  && globalEn ##1 peripheralRequest);
endmodule

/* File: design/pin_edge_sync.sv */
`timescale 1ns/1ps
module pin_edge_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Pin and edge choice
  input  wire logic pinAsync,
  input  wire logic risingSel,
  // Results
  output logic      edgePulse,
  output logic      pinLevel
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic primed_ff;
  wire  agree   = (s2_ff == s3_ff);
  wire  changed = agree && (s3_ff != level_ff);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff     <= 1'b0;
      s2_ff     <= 1'b0;
      s3_ff     <= 1'b0;
      level_ff  <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      s1_ff     <= pinAsync;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      primed_ff <= primed_ff | agree;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

  // The first agreement seeds the level from the reset zeros, so an idle-high pin can still give a rising edge after reset
  assign edgePulse = primed_ff && changed && (s3_ff == risingSel);
  assign pinLevel  = level_ff;
endmodule

/* File: testbench/irq_source_model.sv */
`timescale 1ns/1ps
module irq_source_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Commands from the bench
  input  wire logic [9:0] flagSet,
  input  wire logic [9:0] flagClr,
  input  wire logic       pinCmd,
  // Flag levels and pin
  output logic      [7:0] periphFlags,
  output logic            pinChangeFlag,
  output logic            timer0OverflowFlag,
  output logic            extPin,
  // Core side
  input  wire logic       cpuRequest,
  output logic      [7:0] serviceCount
);
  logic [9:0] flags_ff;
  logic       seen_ff;
  logic       pin_ff;
  logic [7:0] count_ff;

  // Flags hold until their source is cleared, as a real peripheral keeps them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= 10'h000;
      seen_ff  <= 1'b0;
      pin_ff   <= 1'b1;
      count_ff <= 8'h00;
    end else begin
      flags_ff <= (flags_ff & ~flagClr) | flagSet;
      seen_ff  <= cpuRequest;
      pin_ff   <= pinCmd;
      if (cpuRequest && !seen_ff) count_ff <= count_ff + 8'h01;
    end
  end

  assign periphFlags        = flags_ff[7:0];
  assign pinChangeFlag      = flags_ff[8];
  assign timer0OverflowFlag = flags_ff[9];
  assign extPin             = pin_ff;
  assign serviceCount       = count_ff;
endmodule

/* File: testbench/tb_peripheral_interrupt_enables.sv */
`timescale 1ns/1ps
module tb_peripheral_interrupt_enables;
  logic        core_clk;
  logic        nrst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        extPin;
  logic        timer0OverflowFlag;
  logic        pinChangeFlag;
  logic [7:0]  periphFlags;
  logic        cpuInterruptRequest;
  logic        peripheralRequest;
  logic        externalRequest;
  logic        irq;
  logic [9:0]  flagSet;
  logic [9:0]  flagClr;
  logic        pinCmd;
  logic [7:0]  serviceCount;
  logic [31:0] rdData;
  int          errors;
  int          checks_done;
  logic [4:0]  ofs [4] = '{5'h00, 5'h04, 5'h08, 5'h18};
  logic [7:0]  full [4] = '{8'hc1, 8'h31, 8'hff, 8'h00};

  peripheral_interrupt_enables i_dut (.core_clk(core_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .extPin(extPin),
    .timer0OverflowFlag(timer0OverflowFlag), .pinChangeFlag(pinChangeFlag),
    .periphFlags(periphFlags), .cpuInterruptRequest(cpuInterruptRequest),
    .peripheralRequest(peripheralRequest), .externalRequest(externalRequest), .irq(irq));

  irq_source_model i_src (.core_clk(core_clk), .nrst(nrst), .flagSet(flagSet),
    .flagClr(flagClr), .pinCmd(pinCmd), .periphFlags(periphFlags),
    .pinChangeFlag(pinChangeFlag), .timer0OverflowFlag(timer0OverflowFlag), .extPin(extPin),
    .cpuRequest(cpuInterruptRequest), .serviceCount(serviceCount));

  always #50 core_clk = ~core_clk;

  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bitIs(input string w, input logic e, input logic g);
    check(w, {31'h0, e}, {31'h0, g});
  endtask

  // Request held until the rising edge that samples waitrequest low; data taken there
  task automatic avXfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                        input logic be0);
    int n;
    n = 0;
    @(posedge core_clk);
    address    <= a;
    read       <= rd;
    write      <= !rd;
    writedata  <= {24'h000000, d};
    byteenable <= {3'h0, be0};
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      errors++;
      summarize();
    end else begin
      rdData = readdata;
      read  <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    avXfer(1'b0, a, d, 1'b1);
  endtask

  task automatic rdIs(input logic [4:0] a, input logic [7:0] e);
    avXfer(1'b1, a, 8'h00, 1'b1);
    check("readdata", {24'h000000, e}, rdData);
  endtask

  task automatic setFlags(input logic [9:0] f);
    @(posedge core_clk);
    flagSet <= f;
    flagClr <= ~f;
    @(posedge core_clk);
    flagSet <= 10'h000;
    flagClr <= 10'h000;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  // The pin passes a synchronizer, so its latency is only bounded
  task automatic waitExt();
    int n;
    n = 0;
    while (externalRequest !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    bitIs("externalRequest", 1'b1, externalRequest);
    if (externalRequest !== 1'b1) begin
      summarize();
    end
  endtask

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h1;
    writedata = 32'h0;
    flagSet = 10'h000;
    flagClr = 10'h000;
    pinCmd = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (ofs[k]) rdIs(ofs[k], 8'h00);
    rdIs(5'h14, 8'h00);
    foreach (ofs[k]) begin
      wr(ofs[k], 8'hff);
      rdIs(ofs[k], full[k]);
    end
    avXfer(1'b0, 5'h08, 8'h00, 1'b0);
    rdIs(5'h08, 8'hff);
    wr(5'h00, 8'hc0);
    wr(5'h04, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(5'h08, 8'h01 << i);
      setFlags({2'b00, ~(8'h01 << i)});
      bitIs("peripheralRequest", 1'b0, peripheralRequest);
      setFlags({2'b00, 8'h01 << i});
      bitIs("peripheralRequest", 1'b1, peripheralRequest);
      bitIs("cpuInterruptRequest", 1'b1, cpuInterruptRequest);
    end
    wr(5'h00, 8'h80);
    setFlags(10'h0ff);
    wr(5'h08, 8'hff);
    settle();
    bitIs("cpuInterruptRequest", 1'b0, cpuInterruptRequest);
    wr(5'h00, 8'h40);
    settle();
    bitIs("peripheralRequest", 1'b0, peripheralRequest);
    wr(5'h00, 8'h80);
    wr(5'h08, 8'h00);
    setFlags(10'h100);
    bitIs("cpuInterruptRequest", 1'b0, cpuInterruptRequest);
    wr(5'h04, 8'h10);
    settle();
    bitIs("cpuInterruptRequest", 1'b1, cpuInterruptRequest);
    check("serviceCount", 32'd9, {24'h0, serviceCount});
    wr(5'h04, 8'h20);
    settle();
    bitIs("cpuInterruptRequest", 1'b0, cpuInterruptRequest);
    bitIs("irq", 1'b0, irq);
    wr(5'h14, 8'h02);
    settle();
    bitIs("irq", 1'b1, irq);
    rdIs(5'h10, 8'h06);
    settle();
    bitIs("irq", 1'b0, irq);
    setFlags(10'h000);
    wr(5'h04, 8'h01);
    wr(5'h00, 8'h81);
    pinCmd <= 1'b0;
    repeat (10) @(negedge core_clk);
    rdIs(5'h0c, 8'h00);
    pinCmd <= 1'b1;
    waitExt();
    rdIs(5'h0c, 8'h01);
    wr(5'h0c, 8'h01);
    settle();
    bitIs("externalRequest", 1'b0, externalRequest);
    wr(5'h00, 8'h80);
    pinCmd <= 1'b0;
    waitExt();
    wr(5'h00, 8'h00);
    settle();
    bitIs("externalRequest", 1'b0, externalRequest);
    rdIs(5'h0c, 8'h01);
    rdIs(5'h10, 8'h03);
    summarize();
  end
endmodule
